/* conv_regs_pkg.sv */
// constants shared by the converter status and control register bank
`default_nettype none
package conv_regs_pkg;
	// -----------------------------------------------------------------
	// command codes
	// -----------------------------------------------------------------
	localparam logic [7:0] CMD_RUN_MARGIN    = 8'h01;
	localparam logic [7:0] CMD_RUN_SOURCE    = 8'h02;
	localparam logic [7:0] CMD_FAULT_CLEAR   = 8'h03;
	localparam logic [7:0] CMD_WRITE_LOCK    = 8'h10;
	localparam logic [7:0] CMD_SETPOINT      = 8'h21;
	localparam logic [7:0] CMD_STATUS_BYTE   = 8'h78;
	localparam logic [7:0] CMD_STATUS_WORD   = 8'h79;
	localparam logic [7:0] CMD_STATUS_VOLT   = 8'h7A;
	localparam logic [7:0] CMD_STATUS_CURR   = 8'h7B;
	localparam logic [7:0] CMD_STATUS_COMM   = 8'h7E;
	// -----------------------------------------------------------------
	// run/margin control fields
	// -----------------------------------------------------------------
	localparam int          RUN_REQ_BIT      = 7;
	localparam int          MARGIN_MSB       = 5;
	localparam int          MARGIN_LSB       = 2;
	localparam logic [7:0]  RUN_MARGIN_WMASK = 8'hBC;
	localparam logic [7:0]  RUN_MARGIN_RST   = 8'h00;
	localparam logic [3:0]  MARGIN_LOW_IGN   = 4'h5;
	localparam logic [3:0]  MARGIN_LOW_ACT   = 4'h6;
	localparam logic [3:0]  MARGIN_HIGH_IGN  = 4'h9;
	localparam logic [3:0]  MARGIN_HIGH_ACT  = 4'hA;
	// -----------------------------------------------------------------
	// run source config fields
	// -----------------------------------------------------------------
	localparam int          BUS_HONOR_BIT    = 3;
	localparam int          PIN_HONOR_BIT    = 2;
	localparam logic [7:0]  RUN_SRC_CONST    = 8'h13;
	localparam logic [7:0]  RUN_SRC_WMASK    = 8'h0C;
	localparam logic [7:0]  RUN_SRC_RST      = 8'h17;
	// -----------------------------------------------------------------
	// write lock levels
	// -----------------------------------------------------------------
	localparam logic [7:0]  LOCK_NONE        = 8'h00;
	localparam logic [7:0]  LOCK_CTRL_SET    = 8'h20;
	localparam logic [7:0]  LOCK_RUN_ONLY    = 8'h40;
	localparam logic [7:0]  LOCK_ALL         = 8'h80;
	localparam logic [7:0]  LOCK_WMASK       = 8'hE0;
	// -----------------------------------------------------------------
	// status bit positions and setpoint reset value
	// -----------------------------------------------------------------
	localparam int ST_OFF = 6, ST_OV = 5, ST_OC = 4, ST_BIAS = 3, ST_TEMP = 2;
	localparam int ST_COMM_FAULT = 1, ST_OTHER = 0;
	localparam int SH_VOLT = 15, SH_CURR = 14, SH_BIAS = 13, SH_SUPPLY_LOW = 11;
	localparam int COMM_BAD_CMD = 7, COMM_BAD_DATA = 6, COMM_PEC_FAIL = 5;
	localparam int VOLT_FLAG_LSB = 4;
	localparam int CURR_OC = 7, CURR_OCUV = 6, CURR_NEG = 4;
	localparam logic [15:0] SETPOINT_RST = 16'h0133;
endpackage : conv_regs_pkg
`default_nettype wire

/* sticky_flags.sv */
// sticky status flags: set wins over clear
`default_nettype none
module sticky_flags #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] set_in,
	input  wire logic             clear,
	output var  logic [WIDTH-1:0] flags
);
	// a condition still present re-sets the flag on the clear cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			flags <= '0;
		end else begin
			flags <= (clear ? '0 : flags) | set_in;
		end
	end
endmodule // sticky_flags
`default_nettype wire

/* converter_status_control_regs.sv */
// command and status register bank of the converter management port
`default_nettype none
module converter_status_control_regs
(
	// clock and reset
	input  wire logic        SYS_CLK,
	input  wire logic        RST,
	// command port from the bus framing logic
	input  wire logic        CMD_VALID,
	input  wire logic        CMD_WRITE,
	input  wire logic [7:0]  CMD_CODE,
	input  wire logic [15:0] CMD_WDATA,
	input  wire logic        PEC_FAIL,
	output var  logic [15:0] CMD_RDATA,
	output var  logic        CMD_DONE,
	// fault detector levels (asynchronous)
	input  wire logic        OV_FAULT_IN,
	input  wire logic        OV_WARN_IN,
	input  wire logic        UV_WARN_IN,
	input  wire logic        UV_FAULT_IN,
	input  wire logic        OC_FAULT_IN,
	input  wire logic        OCUV_FAULT_IN,
	input  wire logic        NEG_LIMIT_IN,
	input  wire logic        BIAS_UV_IN,
	input  wire logic        TEMP_IN,
	input  wire logic        OTHER_IN,
	input  wire logic        SUPPLY_OK_N_IN,
	input  wire logic        OUTPUT_OFF_IN,
	// converter control
	output var  logic        SWITCH_EN,
	output var  logic        MARGIN_LOW,
	output var  logic        MARGIN_HIGH,
	output var  logic        MARGIN_ACT_FAULT,
	output var  logic        RUN_REQ_PIN_HONOR,
	output var  logic [15:0] SETPOINT_WORD,
	output var  logic        ALERT_N
);
	import conv_regs_pkg::*;
	// ---------------------------------------------------------------
	// input synchronisers
	// ---------------------------------------------------------------
	logic [11:0] det_meta_reg;
	logic [11:0] det_reg;
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			det_meta_reg <= '0;
			det_reg      <= '0;
		end else begin
			det_meta_reg <= {SUPPLY_OK_N_IN, OUTPUT_OFF_IN, OTHER_IN, TEMP_IN, BIAS_UV_IN,
				NEG_LIMIT_IN, OCUV_FAULT_IN, OC_FAULT_IN, UV_FAULT_IN, UV_WARN_IN,
				OV_WARN_IN, OV_FAULT_IN};
			det_reg      <= det_meta_reg;
		end
	end
	logic ov_f, ov_w, uv_w, uv_f, oc_f, ocuv_f, neg_l, bias_uv, temp_f, other_f;
	logic out_off, sup_n;
	assign {sup_n, out_off, other_f, temp_f, bias_uv, neg_l, ocuv_f, oc_f, uv_f, uv_w,
		ov_w, ov_f} = det_reg;
	// ---------------------------------------------------------------
	// command decode and write lock
	// ---------------------------------------------------------------
	logic [7:0]  run_margin_control_reg;
	logic [7:0]  run_source_config_reg;
	logic [7:0]  write_lock_level_reg;
	logic        do_wr;
	logic        do_clear;
	logic        known_cmd;
	logic        wr_allowed;
	logic        lock_ok;
	logic        bad_cmd;
	logic        bad_data;
	always_comb begin
		case (CMD_CODE)
			CMD_RUN_MARGIN, CMD_RUN_SOURCE, CMD_FAULT_CLEAR, CMD_WRITE_LOCK,
			CMD_SETPOINT, CMD_STATUS_BYTE, CMD_STATUS_WORD, CMD_STATUS_VOLT,
			CMD_STATUS_CURR, CMD_STATUS_COMM: known_cmd = 1'b1;
			default: known_cmd = 1'b0;
		endcase
	end
	always_comb begin
		case (write_lock_level_reg)
			LOCK_NONE:     lock_ok = 1'b1;
			LOCK_CTRL_SET: lock_ok = (CMD_CODE == CMD_WRITE_LOCK) || (CMD_CODE == CMD_RUN_MARGIN)
				|| (CMD_CODE == CMD_RUN_SOURCE) || (CMD_CODE == CMD_SETPOINT);
			LOCK_RUN_ONLY: lock_ok = (CMD_CODE == CMD_WRITE_LOCK)
				|| (CMD_CODE == CMD_RUN_MARGIN);
			LOCK_ALL:      lock_ok = (CMD_CODE == CMD_WRITE_LOCK);
			default:       lock_ok = (CMD_CODE == CMD_WRITE_LOCK);
		endcase
	end
	// status reads are read-only; writing them counts as bad data
	logic writable_cmd;
	assign writable_cmd = (CMD_CODE == CMD_RUN_MARGIN) || (CMD_CODE == CMD_RUN_SOURCE)
		|| (CMD_CODE == CMD_WRITE_LOCK) || (CMD_CODE == CMD_SETPOINT)
		|| (CMD_CODE == CMD_FAULT_CLEAR);
	assign wr_allowed = lock_ok && writable_cmd;
	assign do_wr      = CMD_VALID && CMD_WRITE && known_cmd && wr_allowed && !PEC_FAIL;
	assign do_clear   = do_wr && (CMD_CODE == CMD_FAULT_CLEAR);
	assign bad_cmd    = CMD_VALID && !known_cmd;
	assign bad_data   = CMD_VALID && CMD_WRITE && known_cmd && !wr_allowed;
	// ---------------------------------------------------------------
	// control registers
	// ---------------------------------------------------------------
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			write_lock_level_reg <= LOCK_NONE;
		end else if (do_wr && CMD_CODE == CMD_WRITE_LOCK) begin
			write_lock_level_reg <= CMD_WDATA[7:0] & LOCK_WMASK;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			run_margin_control_reg <= RUN_MARGIN_RST;
		end else if (do_wr && CMD_CODE == CMD_RUN_MARGIN) begin
			run_margin_control_reg <= CMD_WDATA[7:0] & RUN_MARGIN_WMASK;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			run_source_config_reg <= RUN_SRC_RST;
		end else if (do_wr && CMD_CODE == CMD_RUN_SOURCE) begin
			run_source_config_reg <= (CMD_WDATA[7:0] & RUN_SRC_WMASK) | RUN_SRC_CONST;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			SETPOINT_WORD <= SETPOINT_RST;
		end else if (do_wr && CMD_CODE == CMD_SETPOINT) begin
			SETPOINT_WORD <= CMD_WDATA;
		end
	end

	// ---------------------------------------------------------------
	// run and margin outputs
	// ---------------------------------------------------------------
	logic       bus_honor;
	logic       run_req;
	logic [3:0] margin_select;
	assign bus_honor     = run_source_config_reg[BUS_HONOR_BIT];
	assign run_req       = run_margin_control_reg[RUN_REQ_BIT];
	assign margin_select = run_margin_control_reg[MARGIN_MSB:MARGIN_LSB];
	// switching follows the run request only when bus control is honored;
	// a latched-off converter is restarted by its own power stage, not here
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			SWITCH_EN         <= 1'b0;
			RUN_REQ_PIN_HONOR <= 1'b1;
		end else begin
			SWITCH_EN         <= bus_honor ? run_req : 1'b0;
			RUN_REQ_PIN_HONOR <= run_source_config_reg[PIN_HONOR_BIT];
		end
	end
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			MARGIN_LOW       <= 1'b0;
			MARGIN_HIGH      <= 1'b0;
			MARGIN_ACT_FAULT <= 1'b0;
		end else begin
			MARGIN_LOW       <= bus_honor && run_req && ((margin_select == MARGIN_LOW_IGN)
				|| (margin_select == MARGIN_LOW_ACT));
			MARGIN_HIGH      <= bus_honor && run_req && ((margin_select == MARGIN_HIGH_IGN)
				|| (margin_select == MARGIN_HIGH_ACT));
			MARGIN_ACT_FAULT <= (margin_select == MARGIN_LOW_ACT)
				|| (margin_select == MARGIN_HIGH_ACT);
		end
	end

	// ---------------------------------------------------------------
	// sticky status flags
	// ---------------------------------------------------------------
	logic [3:0] volt_flags;
	logic [2:0] curr_flags;
	logic [2:0] comm_flags;
	logic [4:0] misc_flags;
	sticky_flags #(.WIDTH(4)) volt_u (
		.clk    (SYS_CLK),
		.rst    (RST),
		.set_in ({ov_f, ov_w, uv_w, uv_f}),
		.clear  (do_clear),
		.flags  (volt_flags)
	);
	sticky_flags #(.WIDTH(3)) curr_u (
		.clk    (SYS_CLK),
		.rst    (RST),
		.set_in ({oc_f, ocuv_f, neg_l}),
		.clear  (do_clear),
		.flags  (curr_flags)
	);
	sticky_flags #(.WIDTH(3)) comm_u (
		.clk    (SYS_CLK),
		.rst    (RST),
		.set_in ({bad_cmd, bad_data, CMD_VALID && PEC_FAIL}),
		.clear  (do_clear),
		.flags  (comm_flags)
	);
	sticky_flags #(.WIDTH(5)) misc_u (
		.clk    (SYS_CLK),
		.rst    (RST),
		.set_in ({bias_uv, temp_f, other_f, out_off, sup_n}),
		.clear  (do_clear),
		.flags  (misc_flags)
	);

	logic [7:0]  volt_byte;
	logic [7:0]  curr_byte;
	logic [7:0]  comm_byte;
	logic [15:0] status_word;
	always_comb begin
		volt_byte = {volt_flags, 4'h0};
		curr_byte = 8'h00;
		curr_byte[CURR_OC]   = curr_flags[2];
		curr_byte[CURR_OCUV] = curr_flags[1];
		curr_byte[CURR_NEG]  = curr_flags[0];
		comm_byte = 8'h00;
		comm_byte[COMM_BAD_CMD]  = comm_flags[2];
		comm_byte[COMM_BAD_DATA] = comm_flags[1];
		comm_byte[COMM_PEC_FAIL] = comm_flags[0];
		status_word = 16'h0000;
		status_word[ST_OFF]   = misc_flags[1];
		status_word[ST_OV]    = volt_flags[3];
		status_word[ST_OC]    = curr_flags[2];
		status_word[ST_BIAS]  = misc_flags[4];
		status_word[ST_TEMP]  = misc_flags[3];
		status_word[ST_COMM_FAULT] = |comm_flags;
		status_word[ST_OTHER] = misc_flags[2];
		status_word[SH_VOLT]  = |volt_flags;
		status_word[SH_CURR]  = |curr_flags;
		status_word[SH_BIAS]  = misc_flags[4];
		status_word[SH_SUPPLY_LOW] = misc_flags[0];
	end
	// ---------------------------------------------------------------
	// read data, done and alert
	// ---------------------------------------------------------------
	logic [15:0] rdata_next;
	always_comb begin
		case (CMD_CODE)
			CMD_RUN_MARGIN:  rdata_next = {8'h00, run_margin_control_reg};
			CMD_RUN_SOURCE:  rdata_next = {8'h00, run_source_config_reg};
			CMD_WRITE_LOCK:  rdata_next = {8'h00, write_lock_level_reg};
			CMD_SETPOINT:    rdata_next = SETPOINT_WORD;
			CMD_STATUS_BYTE: rdata_next = {8'h00, status_word[7:0]};
			CMD_STATUS_WORD: rdata_next = status_word;
			CMD_STATUS_VOLT: rdata_next = {8'h00, volt_byte};
			CMD_STATUS_CURR: rdata_next = {8'h00, curr_byte};
			CMD_STATUS_COMM: rdata_next = {8'h00, comm_byte};
			default:         rdata_next = 16'h0000;
		endcase
	end
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			CMD_RDATA <= 16'h0000;
			CMD_DONE  <= 1'b0;
		end else begin
			CMD_DONE  <= CMD_VALID;
			if (CMD_VALID && !CMD_WRITE) begin
				CMD_RDATA <= rdata_next;
			end
		end
	end
	// alert is released on the clear and comes back while a fault stays
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			ALERT_N <= 1'b1;
		end else begin
			ALERT_N <= do_clear ? 1'b1 : ~(|status_word);
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	sequence clear_issued_s;
		do_clear;
	endsequence
	sequence flags_empty_s;
		(volt_flags == '0 || $past(ov_f || ov_w || uv_w || uv_f));
	endsequence
	lock_level_hold_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(write_lock_level_reg == LOCK_ALL && CMD_VALID && CMD_WRITE
			&& CMD_CODE == CMD_RUN_MARGIN) |=> $stable(run_margin_control_reg))
		else $error("run control changed under full lock");
	lock_ctrl_set_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(write_lock_level_reg == LOCK_CTRL_SET && CMD_VALID && CMD_WRITE && !PEC_FAIL
			&& CMD_CODE == CMD_SETPOINT) |=> SETPOINT_WORD == $past(CMD_WDATA))
		else $error("setpoint write lost at control lock level");
	blocked_flag_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(write_lock_level_reg == LOCK_RUN_ONLY && CMD_VALID && CMD_WRITE
			&& CMD_CODE == CMD_RUN_SOURCE) |=> comm_flags[1] && $stable(run_source_config_reg))
		else $error("blocked write not flagged");
	bad_cmd_flag_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(CMD_VALID && !known_cmd) |=> comm_byte[COMM_BAD_CMD])
		else $error("unknown command not flagged");
	switch_follow_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(bus_honor && run_req) [*2] |-> ##1 SWITCH_EN)
		else $error("switching not started by honored run request");
	switch_ignore_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		!bus_honor |=> !SWITCH_EN)
		else $error("run request acted on without bus honor");
	margin_decode_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(margin_select[3:2] == 2'b00) |=> !MARGIN_LOW && !MARGIN_HIGH)
		else $error("margin active with disabled field");
	src_const_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(run_source_config_reg & ~RUN_SRC_WMASK) == RUN_SRC_CONST)
		else $error("run source constant bits wrong");
	fault_clear_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		clear_issued_s |=> flags_empty_s)
		else $error("voltage flags survived a fault clear");
	alert_release_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		do_clear |=> ALERT_N)
		else $error("alert not released on fault clear");
	refault_set_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(do_clear && oc_f) ##1 !do_clear |-> curr_flags[2] ##1 !ALERT_N)
		else $error("persisting fault not set again");
endmodule // converter_status_control_regs
`default_nettype wire

/* host_cmd_model.sv */
// host-side command source that feeds the register bank one command at a time
`default_nettype none
module host_cmd_model (
	// clock
	input  wire logic        clk,
	// command toward the bank
	output var  logic        valid,
	output var  logic        write,
	output var  logic [7:0]  code,
	output var  logic [15:0] wdata,
	output var  logic        pec_fail,
	// answer from the bank
	input  wire logic [15:0] rdata,
	input  wire logic        done
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		valid = 1'b0;
		write = 1'b0;
		code = 8'h00;
		wdata = 16'h0000;
		pec_fail = 1'b0;
	end

	// ----------------
	// one command per call
	// ----------------
	// idle code and data fields show the inverse so a stale value is never mistaken for live
	task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
		input logic p, output logic [15:0] rd, output logic ok);
		@(posedge clk);
		valid <= 1'b1;
		write <= w;
		code <= c;
		wdata <= d;
		pec_fail <= p;
		@(posedge clk);
		valid <= 1'b0;
		pec_fail <= 1'b0;
		code <= ~c;
		wdata <= ~d;
		#1;
		rd = rdata;
		ok = done;
	endtask
endmodule // host_cmd_model
`default_nettype wire

/* tb_top.sv */
// self-checking bench for the converter status and control register bank
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import conv_regs_pkg::*;
	// ----------------
	// signals
	// ----------------
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic [11:0] det = 12'h000;
	logic        cmd_valid, cmd_write, pec_fail, cmd_done, ok;
	logic [7:0]  cmd_code, v;
	logic [15:0] cmd_wdata, cmd_rdata, setpoint, rdv;
	logic        switch_en, m_low, m_high, m_act, pin_honor, alert_n;
	logic [11:0] d;
	logic [31:0] seed = 32'hEBE51E0D;
	logic [3:0]  codes [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h9, 4'hA};
	int          bad_count = 0;
	int          check_count = 0;
	int          cycles = 0;

	always #10 sys_clk = ~sys_clk;

	host_cmd_model host (.clk(sys_clk), .valid(cmd_valid), .write(cmd_write), .code(cmd_code),
		.wdata(cmd_wdata), .pec_fail(pec_fail), .rdata(cmd_rdata), .done(cmd_done));

	converter_status_control_regs dut (.SYS_CLK(sys_clk), .RST(rst), .CMD_VALID(cmd_valid),
		.CMD_WRITE(cmd_write), .CMD_CODE(cmd_code), .CMD_WDATA(cmd_wdata), .PEC_FAIL(pec_fail),
		.CMD_RDATA(cmd_rdata), .CMD_DONE(cmd_done), .OV_FAULT_IN(det[0]), .OV_WARN_IN(det[1]),
		.UV_WARN_IN(det[2]), .UV_FAULT_IN(det[3]), .OC_FAULT_IN(det[4]),
		.OCUV_FAULT_IN(det[5]), .NEG_LIMIT_IN(det[6]), .BIAS_UV_IN(det[7]), .TEMP_IN(det[8]),
		.OTHER_IN(det[9]), .SUPPLY_OK_N_IN(det[10]), .OUTPUT_OFF_IN(det[11]),
		.SWITCH_EN(switch_en), .MARGIN_LOW(m_low), .MARGIN_HIGH(m_high),
		.MARGIN_ACT_FAULT(m_act), .RUN_REQ_PIN_HONOR(pin_honor), .SETPOINT_WORD(setpoint),
		.ALERT_N(alert_n));

	// ----------------
	// expectations and helpers
	// ----------------
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		xorshift = x ^ (x << 5);
	endfunction

	function automatic logic [15:0] word_exp(input logic [11:0] f, input logic comm_logic_memory_fault);
		word_exp = {|f[3:0], |f[6:4], f[7], 1'b0, f[10], 3'b000,
			1'b0, f[11], f[0], f[4], f[7], f[8], comm_logic_memory_fault, f[9]};
	endfunction

	// margin low/high outputs only follow an honored run request; the action bit does not
	function automatic logic [3:0] ctl_exp(input logic [7:0] r);
		logic lo, hi;
		lo = (r[5:2] == MARGIN_LOW_IGN) || (r[5:2] == MARGIN_LOW_ACT);
		hi = (r[5:2] == MARGIN_HIGH_IGN) || (r[5:2] == MARGIN_HIGH_ACT);
		ctl_exp = {r[7], r[7] & lo, r[7] & hi,
			(r[5:2] == MARGIN_LOW_ACT) || (r[5:2] == MARGIN_HIGH_ACT)};
	endfunction

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic results();
		if (bad_count == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] c, input logic [15:0] x);
		host.xfer(1'b1, c, x, 1'b0, rdv, ok);
		chk("done", 16'h0001, {15'h0, ok});
	endtask

	task automatic rd(input logic [7:0] c);
		host.xfer(1'b0, c, 16'h0000, 1'b0, rdv, ok);
		chk("done", 16'h0001, {15'h0, ok});
	endtask

	task automatic rdb(input logic [7:0] c, input string n, input logic [7:0] e);
		rd(c);
		chk(n, {8'h00, e}, {8'h00, rdv[7:0]});
	endtask

	task automatic ctl(input logic [3:0] e);
		chk("control", {12'h000, e}, {12'h000, switch_en, m_low, m_high, m_act});
	endtask

	task automatic comm(input logic [2:0] e);
		rd(CMD_STATUS_COMM);
		chk("comm_status", {13'h0, e}, {13'h0, rdv[7:5]});
	endtask

	task automatic stat(input logic [11:0] f, input logic comm_logic_memory_fault);
		logic [15:0] w;
		w = word_exp(f, comm_logic_memory_fault);
		rd(CMD_STATUS_WORD);
		chk("status_word", w, rdv);
		rdb(CMD_STATUS_BYTE, "status_byte", w[7:0]);
		rdb(CMD_STATUS_VOLT, "volt_status", {f[0], f[1], f[2], f[3], 4'h0});
		rdb(CMD_STATUS_CURR, "curr_status", {f[4], f[5], 1'b0, f[6], 4'h0});
	endtask

	task automatic drive_det(input logic [11:0] x);
		@(posedge sys_clk);
		det <= x;
		settle(3);
	endtask

	// hang guard, far above the few hundred cycles the sequence needs
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			results();
		end
	end

	// ----------------
	// sequence
	// ----------------
	initial begin
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		#1;
		chk("setpoint", 16'h0133, setpoint);
		chk("pins", 16'h0006, {13'h0, alert_n, pin_honor, switch_en});
		rdb(CMD_RUN_MARGIN, "run_margin", 8'h00);
		rdb(CMD_RUN_SOURCE, "run_source", 8'h17);
		rdb(CMD_WRITE_LOCK, "lock", 8'h00);
		wr(CMD_RUN_MARGIN, 16'h0080);
		settle(1);
		ctl(4'b0000);
		wr(CMD_RUN_SOURCE, 16'h0008);
		rdb(CMD_RUN_SOURCE, "run_source", 8'h1B);
		settle(1);
		ctl(4'b1000);
		chk("pin_honor", 16'h0000, {15'h0, pin_honor});
		for (int i = 0; i < 16; i++) begin
			seed = xorshift(seed);
			v = seed[7:0];
			if (i < 8) begin
				v[5:2] = codes[i];
			end
			wr(CMD_RUN_MARGIN, {8'h00, v});
			settle(1);
			ctl(ctl_exp(v));
			rdb(CMD_RUN_MARGIN, "run_margin", v & RUN_MARGIN_WMASK);
		end
		wr(CMD_RUN_MARGIN, 16'h0080);
		for (int i = 0; i < 6; i++) begin
			seed = xorshift(seed);
			d = (i == 0) ? 12'hFFF : seed[11:0];
			drive_det(d);
			drive_det(12'h000);
			chk("alert_n", {15'h0, d == 12'h000}, {15'h0, alert_n});
			stat(d, 1'b0);
			wr(CMD_FAULT_CLEAR, 16'h0000);
			chk("alert_n", 16'h0001, {15'h0, alert_n});
			stat(12'h000, 1'b0);
			chk("switch_en", 16'h0001, {15'h0, switch_en});
		end
		drive_det(12'h011);
		wr(CMD_FAULT_CLEAR, 16'h0000);
		settle(1);
		chk("alert_n", 16'h0000, {15'h0, alert_n});
		rdb(CMD_STATUS_VOLT, "volt_status", 8'h80);
		rdb(CMD_STATUS_CURR, "curr_status", 8'h80);
		drive_det(12'h000);
		wr(CMD_FAULT_CLEAR, 16'h0000);
		rd(8'h55);
		comm(3'b100);
		host.xfer(1'b1, CMD_RUN_MARGIN, 16'h0000, 1'b1, rdv, ok);
		rdb(CMD_RUN_MARGIN, "run_margin", 8'h80);
		comm(3'b101);
		stat(12'h000, 1'b1);
		wr(CMD_FAULT_CLEAR, 16'h0000);
		comm(3'b000);
		wr(CMD_WRITE_LOCK, 16'h0020);
		rdb(CMD_WRITE_LOCK, "lock", 8'h20);
		wr(CMD_SETPOINT, 16'h0266);
		settle(1);
		chk("setpoint", 16'h0266, setpoint);
		rd(CMD_SETPOINT);
		chk("setpoint_rd", 16'h0266, rdv);
		wr(CMD_RUN_SOURCE, 16'h000C);
		rdb(CMD_RUN_SOURCE, "run_source", 8'h1F);
		wr(CMD_WRITE_LOCK, 16'h0040);
		wr(CMD_RUN_SOURCE, 16'h0008);
		rdb(CMD_RUN_SOURCE, "run_source", 8'h1F);
		wr(CMD_SETPOINT, 16'h0133);
		settle(1);
		chk("setpoint", 16'h0266, setpoint);
		wr(CMD_RUN_MARGIN, 16'h0094);
		rdb(CMD_RUN_MARGIN, "run_margin", 8'h94);
		comm(3'b010);
		wr(CMD_WRITE_LOCK, 16'h0080);
		wr(CMD_RUN_MARGIN, 16'h0080);
		rdb(CMD_RUN_MARGIN, "run_margin", 8'h94);
		wr(CMD_WRITE_LOCK, 16'h0000);
		rdb(CMD_WRITE_LOCK, "lock", 8'h00);
		wr(CMD_FAULT_CLEAR, 16'h0000);
		comm(3'b000);
		wr(CMD_RUN_SOURCE, 16'h0008);
		rdb(CMD_RUN_SOURCE, "run_source", 8'h1B);
		results();
	end
endmodule // tb_top
`default_nettype wire
